// [rtl/angle_result_consts.vh]
`ifndef ANGLE_RESULT_CONSTS_VH
`define ANGLE_RESULT_CONSTS_VH

// Register offsets
`define ADDR_TALLY 8'h10
`define ADDR_TRIM 8'h11
`define ADDR_ANGLE 8'h13
`define ADDR_LENGTH 8'h14

// Trim register fields
`define TRIM_SEL_HI 15
`define TRIM_SEL_LO 14
`define TRIM_GAIN_HI 10
`define TRIM_GAIN_LO 0
`define TRIM_RESET 16'h0000
`define RESULT_RESET 16'h0000

// Tally control codes
`define TALLY_CLEAR 2'h0
`define TALLY_FAST 2'h1
`define TALLY_SLOW 2'h2
`define TALLY_HOLD 2'h3

// Operating modes and sequences
`define MODE_TRIG_A 3'h0
`define MODE_TRIG_B 3'h1
`define MODE_CONT 3'h2
`define MODE_TRIG_C 3'h3
`define SEQ_XZX 4'hD
`define AXIS_NONE 2'h0
`define AXIS_X 2'h1
`define AXIS_Y 2'h2
`define AXIS_Z 2'h3

// Angle arithmetic, sixteenths of a degree
`define DEG360 20'h01680
`define DEG180 20'h00B40
`define MAG_SCALE 10'h137
`define CORDIC_LAST 4'h9

// Timing, ns, and the clock rate
`define CLK_MHZ 250
`define SPIN_NS 4000
`define ADC_NS 2000
`define UPDATE_NS 25000
`define WAKE_A_NS 1000
`define WAKE_B_NS 2000
`define WAKE_C_NS 3000
`define NS_TO_CYC(t) ((((t) * `CLK_MHZ) + 999) / 1000)

`endif

// [rtl/angle_result_and_conversion.v]
// Behaviour
// - Count cycles of the chosen oscillator; tally reads as 16 bits, read-only.
// - The tally wraps to zero past its maximum and keeps counting.
// - Control code 0 clears, 1 counts fast, 2 counts slow, 3 holds.
// - Axis-select field picks trimmed axis: 0 none, 1 X, 2 Y, 3 Z.
// - Host writes 11-bit gain; selected axis is scaled by gain over 1024.
// - Angle reads 0 to 360 degrees, unsigned, in the low 13 bits.
// - Low four angle bits hold the fraction in sixteenths of a degree.
// - A read-only 16-bit value holds the vector length of the two axes.
// - Angle comes from exactly two axes chosen by a configuration field.
// - Mode 010b converts continuously without triggers.
// - Each conversion spins and integrates, then digitises into the result.
// - Spinning of the next sample overlaps digitising of the previous one.
// - In continuous mode the update interval sets the sample rate.
// - Modes 000b, 001b, 011b convert once per trigger after a mode-set delay.
// - SPI command, alert pin or chip select each start a triggered conversion.
// - Enable code 1101b converts X, Z, X.
// - Result registers change only when a conversion completes.
`timescale 1ns/10ps
`default_nettype none
`include "angle_result_consts.vh"

module angle_result_and_conversion #(
  parameter [15:0] SPIN_CYC = `NS_TO_CYC(`SPIN_NS),
  parameter [15:0] ADC_CYC = `NS_TO_CYC(`ADC_NS),
  parameter [15:0] UPDATE_CYC = `NS_TO_CYC(`UPDATE_NS)
) (
  input wire mclk,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  input wire [1:0] tally_control,
  input wire fast_internal_oscillator,
  input wire slow_internal_oscillator,
  input wire [2:0] operating_mode,
  input wire [3:0] axis_conversion_enables,
  input wire [1:0] angle_pick,
  input wire spi_trigger,
  input wire alert_n,
  input wire chip_select_n,
  input wire signed [15:0] sample_x,
  input wire signed [15:0] sample_y,
  input wire signed [15:0] sample_z,
  output reg conv_busy,
  output reg conv_done
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAKE = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;
  localparam [15:0] WAKE_A_CYC = `NS_TO_CYC(`WAKE_A_NS) - 1;
  localparam [15:0] WAKE_B_CYC = `NS_TO_CYC(`WAKE_B_NS) - 1;
  localparam [15:0] WAKE_C_CYC = `NS_TO_CYC(`WAKE_C_NS) - 1;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [1:0] seq_axis;
    input [3:0] en;
    input [1:0] idx;
    reg [1:0] n;
    integer k;
    begin
      seq_axis = `AXIS_NONE;
      n = 2'h0;
      if (en == `SEQ_XZX) begin
        if (idx == 2'h1)
          seq_axis = `AXIS_Z;
        else if (idx != 2'h3)
          seq_axis = `AXIS_X;
      end else begin
        for (k = 0; k < 3; k = k + 1) begin
          if (en[k]) begin
            if (n == idx)
              seq_axis = k[1:0] + 2'h1;
            n = n + 2'h1;
          end
        end
      end
    end
  endfunction

  function signed [19:0] apply_trim;
    input signed [15:0] v;
    input hit;
    input [10:0] g;
    reg signed [27:0] p;
    begin
      p = v * $signed({1'b0, g});
      if (hit)
        apply_trim = {{2{p[27]}}, p[27:10]};
      else
        apply_trim = {{4{v[15]}}, v};
    end
  endfunction

  function signed [19:0] atan_step;
    input [3:0] i;
    begin
      case (i)
        4'h0: atan_step = 20'sh002D0;
        4'h1: atan_step = 20'sh001A9;
        4'h2: atan_step = 20'sh000E1;
        4'h3: atan_step = 20'sh00072;
        4'h4: atan_step = 20'sh00039;
        4'h5: atan_step = 20'sh0001D;
        4'h6: atan_step = 20'sh0000E;
        4'h7: atan_step = 20'sh00007;
        4'h8: atan_step = 20'sh00004;
        default: atan_step = 20'sh00002;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [3:0] sync_a;
  reg [3:0] sync_b;
  reg [3:0] sync_c;
  wire [3:0] pins_in;
  wire fast_rise;
  wire slow_rise;
  wire alert_fall;
  wire cs_rise;

  assign pins_in = {chip_select_n, alert_n, slow_internal_oscillator,
                    fast_internal_oscillator};

  always @(posedge mclk) begin
    if (srst) begin
      sync_a <= 4'hF;
      sync_b <= 4'hF;
      sync_c <= 4'hF;
    end else begin
      sync_a <= pins_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign fast_rise = sync_b[0] & ~sync_c[0];
  assign slow_rise = sync_b[1] & ~sync_c[1];
  assign alert_fall = ~sync_b[2] & sync_c[2];
  assign cs_rise = sync_b[3] & ~sync_c[3];

  // ----------------------------------------
  // Oscillator tally
  // ----------------------------------------
  reg [15:0] tally;

  always @(posedge mclk) begin
    if (srst) begin
      tally <= `RESULT_RESET;
    end else begin
      case (tally_control)
        `TALLY_CLEAR: tally <= `RESULT_RESET;
        `TALLY_FAST: tally <= tally + {15'h0000, fast_rise};
        `TALLY_SLOW: tally <= tally + {15'h0000, slow_rise};
        default: tally <= tally;
      endcase
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  reg [2:0] state;
  reg [15:0] wake_cnt;
  reg [15:0] tick_cnt;
  reg [1:0] seq_idx;
  reg seq_open;
  reg spin_busy;
  reg [15:0] spin_cnt;
  reg [1:0] spin_axis;
  reg adc_busy;
  reg [15:0] adc_cnt;
  reg [1:0] adc_axis;
  reg signed [15:0] adc_val;
  reg [3:0] done;
  reg signed [15:0] x_res;
  reg signed [15:0] y_res;
  reg signed [15:0] z_res;
  reg [15:0] trim;
  reg cordic_busy;
  reg [15:0] wake_load;
  reg signed [15:0] spin_sample;
  reg [1:0] pick_h;
  reg [1:0] pick_v;

  wire is_cont = operating_mode == `MODE_CONT;
  wire is_trig = operating_mode == `MODE_TRIG_A || operating_mode == `MODE_TRIG_B ||
                 operating_mode == `MODE_TRIG_C;
  wire trigger = spi_trigger | alert_fall | cs_rise;
  wire [1:0] cur_axis = seq_axis(axis_conversion_enables, seq_idx);
  wire [1:0] nxt_axis = seq_axis(axis_conversion_enables, seq_idx + 2'h1);
  wire restart = state == ST_RUN && is_cont && tick_cnt == 16'h0000;
  wire issue = state == ST_RUN && seq_open && !restart && !spin_busy;
  wire spin_end = spin_busy && spin_cnt == 16'h0000 && !adc_busy;
  wire adc_end = adc_busy && adc_cnt == 16'h0000;
  wire launch = angle_pick != 2'h0 && done[pick_h] && done[pick_v] && !cordic_busy;
  // Pending launch keeps the sequencer busy until the angle is out
  wire pipe_empty = !spin_busy && !adc_busy && !cordic_busy && !launch;

  always @* begin
    case (operating_mode)
      `MODE_TRIG_B: wake_load = WAKE_B_CYC;
      `MODE_TRIG_C: wake_load = WAKE_C_CYC;
      default: wake_load = WAKE_A_CYC;
    endcase
    case (spin_axis)
      `AXIS_Y: spin_sample = sample_y;
      `AXIS_Z: spin_sample = sample_z;
      default: spin_sample = sample_x;
    endcase
    case (angle_pick)
      2'h2: begin
        pick_h = `AXIS_Y;
        pick_v = `AXIS_Z;
      end
      2'h3: begin
        pick_h = `AXIS_X;
        pick_v = `AXIS_Z;
      end
      default: begin
        pick_h = `AXIS_X;
        pick_v = `AXIS_Y;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      state <= ST_IDLE;
      wake_cnt <= 16'h0000;
      tick_cnt <= 16'h0000;
      seq_idx <= 2'h0;
      seq_open <= 1'b0;
      spin_busy <= 1'b0;
      spin_cnt <= 16'h0000;
      spin_axis <= `AXIS_NONE;
      adc_busy <= 1'b0;
      adc_cnt <= 16'h0000;
      adc_axis <= `AXIS_NONE;
      adc_val <= 16'sh0000;
      done <= 4'h0;
      x_res <= 16'sh0000;
      y_res <= 16'sh0000;
      z_res <= 16'sh0000;
      conv_busy <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      conv_busy <= state != ST_IDLE;
      conv_done <= adc_end;
      case (state)
        ST_IDLE: begin
          if (is_cont) begin
            state <= ST_RUN;
            tick_cnt <= 16'h0000;
          end else if (is_trig && trigger && pipe_empty) begin
            state <= ST_WAKE;
            wake_cnt <= wake_load;
          end
        end
        ST_WAKE: begin
          if (wake_cnt == 16'h0000) begin
            state <= ST_RUN;
            seq_open <= 1'b1;
            seq_idx <= 2'h0;
            done <= 4'h0;
          end else begin
            wake_cnt <= wake_cnt - 16'h0001;
          end
        end
        ST_RUN: begin
          if (restart) begin
            tick_cnt <= UPDATE_CYC - 16'h0001;
            seq_open <= 1'b1;
            seq_idx <= 2'h0;
            done <= 4'h0;
          end else if (is_cont) begin
            tick_cnt <= tick_cnt - 16'h0001;
          end else if (!seq_open && pipe_empty) begin
            state <= ST_IDLE;
          end
          if (!is_cont && !is_trig)
            seq_open <= 1'b0;
        end
        default: state <= ST_IDLE;
      endcase
      if (issue) begin
        if (cur_axis != `AXIS_NONE) begin
          spin_busy <= 1'b1;
          spin_cnt <= SPIN_CYC - 16'h0001;
          spin_axis <= cur_axis;
        end
        seq_idx <= seq_idx + 2'h1;
        if (cur_axis == `AXIS_NONE || nxt_axis == `AXIS_NONE || seq_idx == 2'h2)
          seq_open <= 1'b0;
      end
      if (spin_busy && spin_cnt != 16'h0000)
        spin_cnt <= spin_cnt - 16'h0001;
      if (spin_end) begin
        spin_busy <= 1'b0;
        adc_busy <= 1'b1;
        adc_cnt <= ADC_CYC - 16'h0001;
        adc_axis <= spin_axis;
        adc_val <= spin_sample;
      end
      if (adc_busy && adc_cnt != 16'h0000)
        adc_cnt <= adc_cnt - 16'h0001;
      if (launch) begin
        done[pick_h] <= 1'b0;
        done[pick_v] <= 1'b0;
      end
      if (adc_end) begin
        adc_busy <= 1'b0;
        done[adc_axis] <= 1'b1;
        case (adc_axis)
          `AXIS_Y: y_res <= adc_val;
          `AXIS_Z: z_res <= adc_val;
          default: x_res <= adc_val;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Angle and vector length
  // ----------------------------------------
  reg signed [19:0] cx;
  reg signed [19:0] cy;
  reg signed [19:0] cz;
  reg [3:0] step;
  reg [15:0] angle_out;
  reg [15:0] length_out;
  reg signed [15:0] raw_h;
  reg signed [15:0] raw_v;

  wire [1:0] trim_sel = trim[`TRIM_SEL_HI:`TRIM_SEL_LO];
  wire [10:0] trim_gain = trim[`TRIM_GAIN_HI:`TRIM_GAIN_LO];
  wire signed [19:0] th = apply_trim(raw_h, trim_sel == pick_h, trim_gain);
  wire signed [19:0] tv = apply_trim(raw_v, trim_sel == pick_v, trim_gain);
  wire signed [19:0] cz_wrap = cz + `DEG360;
  wire [29:0] mag_prod = cx[19:0] * `MAG_SCALE;

  always @* begin
    case (pick_h)
      `AXIS_Y: raw_h = y_res;
      default: raw_h = x_res;
    endcase
    case (pick_v)
      `AXIS_Y: raw_v = y_res;
      default: raw_v = z_res;
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      cx <= 20'sh00000;
      cy <= 20'sh00000;
      cz <= 20'sh00000;
      step <= 4'h0;
      cordic_busy <= 1'b0;
      angle_out <= `RESULT_RESET;
      length_out <= `RESULT_RESET;
    end else if (launch) begin
      cordic_busy <= 1'b1;
      step <= 4'h0;
      if (th < 0) begin
        cx <= -th;
        cy <= -tv;
        cz <= `DEG180;
      end else begin
        cx <= th;
        cy <= tv;
        cz <= 20'sh00000;
      end
    end else if (cordic_busy) begin
      // Extra cycle so the last step reaches the outputs
      if (step == `CORDIC_LAST + 4'h1) begin
        cordic_busy <= 1'b0;
        if (cz < 0)
          angle_out <= {3'h0, cz_wrap[12:0]};
        else
          angle_out <= {3'h0, cz[12:0]};
        length_out <= mag_prod[24:9];
      end else begin
        if (cy >= 0) begin
          cx <= cx + (cy >>> step);
          cy <= cy - (cx >>> step);
          cz <= cz + atan_step(step);
        end else begin
          cx <= cx - (cy >>> step);
          cy <= cy + (cx >>> step);
          cz <= cz - atan_step(step);
        end
        step <= step + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      trim <= `TRIM_RESET;
      reg_rdata <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == `ADDR_TRIM)
        trim <= {reg_wdata[15:14], 3'h0, reg_wdata[10:0]};
      case (reg_addr)
        `ADDR_TALLY: reg_rdata <= tally;
        `ADDR_TRIM: reg_rdata <= trim;
        `ADDR_ANGLE: reg_rdata <= angle_out;
        `ADDR_LENGTH: reg_rdata <= length_out;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// [verif/angle_result_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module angle_result_properties #(
  parameter [15:0] SPIN_CYC = 16'h0008,
  parameter [15:0] ADC_CYC = 16'h0004,
  parameter [15:0] UPDATE_CYC = 16'h0028
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic [2:0] operating_mode,
  input wire logic [3:0] axis_conversion_enables,
  input wire logic spi_trigger,
  input wire logic conv_busy,
  input wire logic conv_done
);
  localparam int LAT_LO = 250 + SPIN_CYC + ADC_CYC;
  localparam int LAT_HI = 262 + SPIN_CYC + ADC_CYC;
  localparam int UPD_LO = UPDATE_CYC - 2;
  localparam int UPD_HI = UPDATE_CYC + 2;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // ------
  // Port checks
  // ------
  sequence s_trim_write;
    reg_wr && reg_addr == 8'h11 ##1 (reg_addr == 8'h11 && !reg_wr) [*2];
  endsequence
  sequence s_spi_start;
    spi_trigger && operating_mode == 3'h0 && axis_conversion_enables == 4'h1 && !conv_busy;
  endsequence
  sequence s_idle_angle;
    (reg_addr == 8'h13 && !conv_busy && !conv_done) [*3];
  endsequence
  a_trim_readback: assert property (
    s_trim_write |=> reg_rdata == ($past(reg_wdata, 3) & 16'hC7FF))
    else $error("trim readback wrong");
  a_trim_reserved: assert property (
    reg_addr == 8'h11 |=> reg_rdata[13:11] == 3'h0)
    else $error("trim reserved bits set");
  a_unmapped_zero: assert property (
    !(reg_addr inside {8'h10, 8'h11, 8'h13, 8'h14}) |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_angle_range: assert property (
    reg_addr == 8'h13 |=> reg_rdata <= 16'h1680)
    else $error("angle above full turn");
  a_done_while_busy: assert property (
    conv_done |-> $past(conv_busy))
    else $error("done without conversion");
  a_idle_angle_hold: assert property (
    s_idle_angle |-> $stable(reg_rdata))
    else $error("angle changed while idle");
  a_trig_latency: assert property (
    s_spi_start |-> ##[LAT_LO:LAT_HI] conv_done)
    else $error("triggered result late");
  a_cont_period: assert property (
    conv_done && operating_mode == 3'h2
      |-> ##[UPD_LO:UPD_HI] (conv_done || operating_mode != 3'h2))
    else $error("continuous update missing");
endmodule
bind angle_result_and_conversion angle_result_properties #(
  .SPIN_CYC(SPIN_CYC), .ADC_CYC(ADC_CYC), .UPDATE_CYC(UPDATE_CYC)
) i_angle_result_properties (
  .mclk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .operating_mode,
  .axis_conversion_enables, .spi_trigger, .conv_busy, .conv_done
);
`default_nettype wire

// [verif/host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic mclk,
  input wire logic [15:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic spi_trigger,
  output logic alert_n,
  output logic chip_select_n
);
  // ------
  // Host side of register port
  // ------
  // Drift compensation never requested
  localparam logic [1:0] magnet_drift_comp = 2'h0;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    spi_trigger = 1'b0;
    alert_n = 1'b1;
    chip_select_n = 1'b1;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(negedge mclk);
    reg_addr = a;
    @(negedge mclk);
    v = reg_rdata;
  endtask
  task automatic trig(input int kind);
    @(negedge mclk);
    spi_trigger = (kind == 0);
    alert_n = (kind != 1);
    chip_select_n = (kind != 2);
    @(negedge mclk);
    spi_trigger = 1'b0;
    repeat (3) @(negedge mclk);
    alert_n = 1'b1;
    chip_select_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic mclk, srst, fast_osc, slow_osc, reg_wr, spi_trigger, alert_n, chip_select_n;
  logic conv_busy, conv_done;
  logic [1:0] tally_control, angle_pick;
  logic [2:0] operating_mode;
  logic [3:0] axis_conversion_enables;
  logic signed [15:0] sample_x, sample_y, sample_z;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  int n_mismatch, comparisons, cyc, n_edges, lat, i;
  angle_result_and_conversion #(.SPIN_CYC(16'h0008), .ADC_CYC(16'h0004), .UPDATE_CYC(16'h0028))
    i_angle_result_and_conversion (
    .mclk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .tally_control,
    .fast_internal_oscillator(fast_osc), .slow_internal_oscillator(slow_osc), .operating_mode,
    .axis_conversion_enables, .angle_pick, .spi_trigger, .alert_n, .chip_select_n,
    .sample_x, .sample_y, .sample_z, .conv_busy, .conv_done);
  host_model i_host_model (
    .mclk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .spi_trigger, .alert_n, .chip_select_n);
  // ------
  // Clocks and helpers
  // ------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    fast_osc = 1'b0;
    forever #16 fast_osc = ~fast_osc;
  end
  initial begin
    slow_osc = 1'b0;
    forever #100 slow_osc = ~slow_osc;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  always @(posedge fast_osc) if (tally_control == 2'h1) n_edges++;
  always @(posedge slow_osc) if (tally_control == 2'h2) n_edges++;
  function automatic logic [15:0] near(logic [15:0] v, int e, int t);
    if (v >= e - t && v <= e + t) return v;
    return e[15:0];
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic convert(input logic [2:0] m, input int kind);
    int t0;
    int k;
    operating_mode = m;
    repeat (2) @(negedge mclk);
    t0 = cyc;
    i_host_model.trig(kind);
    k = 0;
    while (conv_done !== 1'b1 && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    lat = cyc - t0;
    while (conv_busy !== 1'b0 && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 3000) begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  task automatic ang(input logic [3:0] en, input logic [1:0] pk, input logic [15:0] tr,
      input logic [15:0] x, input logic [15:0] y, input logic [15:0] z, input int ea, el);
    axis_conversion_enables = en;
    angle_pick = pk;
    sample_x = x;
    sample_y = y;
    sample_z = z;
    i_host_model.wr(8'h11, tr);
    convert(3'h0, 0);
    i_host_model.rd(8'h13, d);
    chk("angle", d, near(d, ea, 3));
    i_host_model.rd(8'h14, d);
    chk("length", d, near(d, el, 4));
  endtask
  // ------
  // Scenarios
  // ------
  initial begin
    srst = 1'b1;
    tally_control = 2'h3;
    operating_mode = 3'h7;
    axis_conversion_enables = 4'h1;
    angle_pick = 2'h0;
    sample_x = 16'h03E8;
    sample_y = 16'h0000;
    sample_z = 16'h0000;
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    for (i = 16; i < 21; i++) begin
      i_host_model.rd(i[7:0], d);
      chk("reset value", d, 16'h0000);
    end
    for (i = 0; i < 4; i++) begin
      i_host_model.wr(8'h11, {i[1:0], 14'h3AA5});
      i_host_model.rd(8'h11, d);
      chk("trim", d, {i[1:0], 14'h02A5});
    end
    i_host_model.wr(8'h13, 16'hFFFF);
    i_host_model.wr(8'h10, 16'hFFFF);
    i_host_model.rd(8'h13, d);
    chk("angle write", d, 16'h0000);
    i_host_model.rd(8'h10, d);
    chk("tally write", d, 16'h0000);
    for (i = 1; i < 3; i++) begin
      tally_control = 2'h0;
      repeat (8) @(negedge mclk);
      n_edges = 0;
      tally_control = i[1:0];
      repeat (200) @(negedge mclk);
      tally_control = 2'h3;
      i_host_model.rd(8'h10, d);
      chk("tally count", d, near(d, n_edges, 1));
      repeat (20) @(negedge mclk);
      i_host_model.rd(8'h10, d);
      chk("tally hold", d, near(d, n_edges, 1));
    end
    tally_control = 2'h0;
    repeat (8) @(negedge mclk);
    i_host_model.rd(8'h10, d);
    chk("tally clear", d, 16'h0000);
    for (i = 0; i < 3; i++) begin
      convert(i == 2 ? 3'h3 : i[2:0], i);
      chk("wake", lat[15:0], near(lat[15:0], 250 * (i + 1) + 16 + 3 * i, 8));
    end
    ang(4'h3, 2'h1, 16'h0000, 16'h03E8, 16'h03E8, 16'h0000, 720, 1414);
    ang(4'h3, 2'h1, 16'h0000, 16'hFC18, 16'h03E8, 16'h0000, 2160, 1414);
    ang(4'h3, 2'h1, 16'h0000, 16'hFC18, 16'hFC18, 16'h0000, 3600, 1414);
    ang(4'h3, 2'h1, 16'h4200, 16'h03E8, 16'h03E8, 16'h0000, 1015, 1118);
    ang(4'h3, 2'h1, 16'h8200, 16'h03E8, 16'h03E8, 16'h0000, 425, 1118);
    ang(4'h6, 2'h2, 16'hC200, 16'h0000, 16'h03E8, 16'h03E8, 425, 1118);
    ang(4'hD, 2'h3, 16'h0000, 16'h03E8, 16'h0000, 16'hFC18, 5040, 1414);
    sample_z = 16'h03E8;
    repeat (60) @(negedge mclk);
    i_host_model.rd(8'h13, d);
    chk("angle idle", d, near(d, 5040, 3));
    axis_conversion_enables = 4'h3;
    angle_pick = 2'h1;
    i_host_model.wr(8'h11, 16'h0000);
    sample_y = 16'h03E8;
    operating_mode = 3'h2;
    repeat (100) @(negedge mclk);
    i_host_model.rd(8'h13, d);
    chk("continuous", d, near(d, 720, 3));
    i_host_model.trig(0);
    sample_y = 16'hFC18;
    repeat (100) @(negedge mclk);
    i_host_model.rd(8'h13, d);
    chk("continuous", d, near(d, 5040, 3));
    operating_mode = 3'h7;
    repeat (60) @(negedge mclk);
    print_verdict();
  end
endmodule
`default_nettype wire
